// ==== rtl/eeprom_serial_slave.sv ====
// Register access over Wishbone and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
// Functional notes
// [R01] data changes only while clock low
// [R02] start is data fall, clock high
// [R03] ignore bus until a start
// [R04] stop returns slave to standby
// [R05] release after eight bits, ack ninth
// [R06] acknowledge matching device-select byte
// [R07] acknowledge every byte of a write
// [R08] read: send byte, release, sample ack
// [R09] no ack: stop sending, await stop
// [R10] select byte msb first, type, dir
// [R11] bits 3..1 match select pins
// [R12] second type code selects protection register
// [R13] current-address read returns counter byte
// [R14] random read: address, restart, read
// [R15] sequential read continues while acked
// [R16] byte write needs write-protect low
// [R17] page write up to sixteen bytes
// [R18] program cycle after write, no ack
// [R19] address counter increments per byte
module eeprom_serial_slave
	import eeprom_serial_pkg::*;
#(
	parameter int PROG_CYCLES = PROG_CYCLES_DEF,
	parameter logic [3:0] MEM_TYPE = 4'hC, // arbitrary value
	parameter logic [3:0] PROT_TYPE = 4'h3 // arbitrary value
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n_o,
	input wire logic select_pin_bit2_i,
	input wire logic select_pin_bit1_i,
	input wire logic select_pin_bit0_i,
	input wire logic write_protect_input_i,
	input wire logic [11:0] adr_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	input wire logic we_i,
	input wire logic [3:0] sel_i,
	input wire logic stb_i,
	input wire logic cyc_i,
	output logic ack_o
);
	core_t s_ff;
	core_t nxt_s;
	logic [7:0] mem [0:255];
	logic rise, fall, start, stop;
	logic match, do_commit, load_rd, req, mem_hit;
	logic [7:0] rbyte;
	logic [2:0] pins;

	// edges seen on the sampled lines; pins are already synchronous
	assign rise = !s_ff.scl_q && scl_i;
	assign fall = s_ff.scl_q && !scl_i;
	assign start = s_ff.scl_q && scl_i && s_ff.sda_q && !sda_i; // R02
	assign stop = s_ff.scl_q && scl_i && !s_ff.sda_q && sda_i; // R04
	assign pins = {select_pin_bit2_i, select_pin_bit1_i, select_pin_bit0_i};
	// type code in the upper nibble, select pins in bits 3..1
	assign match = (s_ff.shreg[3:1] == pins) && // R11
		(s_ff.shreg[7:4] == MEM_TYPE || s_ff.shreg[7:4] == PROT_TYPE); // R10
	assign rbyte = s_ff.prot_sel ? s_ff.prot : mem[s_ff.addr];
	assign req = cyc_i && stb_i && !s_ff.ack;
	assign mem_hit = adr_i[11:10] == MEM_WIN;

	// open drain: only ever pulls low
	assign sda_o = 1'b0;
	assign sda_oe_n_o = s_ff.oe_n;
	assign ack_o = s_ff.ack;
	assign dat_o = s_ff.dat;

	// next-state logic for the serial engine and the register slave
	always_comb begin
		nxt_s = s_ff;
		do_commit = 1'b0;
		load_rd = 1'b0;
		nxt_s.scl_q = scl_i;
		nxt_s.sda_q = sda_i;
		// program timer; the bus stays deaf until it expires
		if (s_ff.busy) begin
			nxt_s.pcnt = s_ff.pcnt + 32'h1;
			if (s_ff.pcnt == 32'(PROG_CYCLES - 1)) begin
				nxt_s.busy = 1'b0; // R18
			end
		end
		if (stop) begin
			nxt_s.state = S_IDLE; // R04
			nxt_s.oe_n = 1'b1;
			if (s_ff.pmask != 16'h0 || s_ff.ppend) begin
				do_commit = 1'b1; // R18
				nxt_s.busy = 1'b1;
				nxt_s.pcnt = 32'h0;
				nxt_s.pmask = 16'h0;
				nxt_s.ppend = 1'b0;
			end
		end else if (start) begin
			// a start during the program cycle is not answered
			if (s_ff.en && !s_ff.busy) begin // R18
				nxt_s.state = S_DSEL; // R02
				nxt_s.bitcnt = 4'h0;
				nxt_s.oe_n = 1'b1;
			end else begin
				// a refused start also drops any pull, so the line is free
				nxt_s.state = S_IDLE;
				nxt_s.oe_n = 1'b1;
			end
		end else begin
			case (s_ff.state)
				S_IDLE, S_WSTOP: begin
					nxt_s.oe_n = 1'b1; // R03
				end
				S_DSEL, S_ADDR, S_WDAT: begin
					if (rise) begin
						// msb arrives first
						nxt_s.shreg = {s_ff.shreg[6:0], sda_i}; // R10
						nxt_s.bitcnt = s_ff.bitcnt + 4'h1;
					end else if (fall && s_ff.bitcnt == BITS_PER_BYTE) begin
						nxt_s.bitcnt = 4'h0;
						// ack is driven only after the clock went low
						nxt_s.oe_n = 1'b0; // R01 R05
						if (s_ff.state == S_DSEL) begin
							if (match) begin
								nxt_s.state = S_ACKS; // R06
								nxt_s.rd = s_ff.shreg[0];
								nxt_s.prot_sel = s_ff.shreg[7:4] == PROT_TYPE; // R12
							end else begin
								nxt_s.oe_n = 1'b1;
								nxt_s.state = S_WSTOP;
							end
						end else if (s_ff.state == S_ADDR) begin
							nxt_s.addr = s_ff.shreg; // R14
							nxt_s.pbase = s_ff.shreg[7:4];
							nxt_s.state = S_ACKA;
						end else begin
							// protected bytes are still acked, just not kept
							if (!write_protect_input_i) begin // R16
								if (s_ff.prot_sel) begin
									nxt_s.ppend = 1'b1;
									nxt_s.pval = s_ff.shreg;
								end else begin
									// buffer wraps inside the page
									nxt_s.pbuf[s_ff.addr[3:0]] = s_ff.shreg; // R17
									nxt_s.pmask[s_ff.addr[3:0]] = 1'b1;
								end
							end
							nxt_s.addr = s_ff.addr + 8'h1; // R19
							nxt_s.state = S_ACKW; // R07
						end
					end
				end
				S_ACKS: begin
					if (fall) begin
						nxt_s.oe_n = 1'b1; // R05
						if (s_ff.rd) begin
							load_rd = 1'b1; // R13
						end else begin
							nxt_s.state = S_ADDR;
						end
					end
				end
				S_ACKA, S_ACKW: begin
					if (fall) begin
						nxt_s.oe_n = 1'b1; // R05
						nxt_s.state = S_WDAT;
					end
				end
				S_RDAT: begin
					if (rise) begin
						nxt_s.bitcnt = s_ff.bitcnt + 4'h1;
					end else if (fall) begin
						if (s_ff.bitcnt == BITS_PER_BYTE) begin
							nxt_s.oe_n = 1'b1; // R08
							nxt_s.state = S_RACK;
						end else begin
							nxt_s.oe_n = s_ff.shreg[6]; // R01
							nxt_s.shreg = {s_ff.shreg[6:0], 1'b0};
						end
					end
				end
				S_RACK: begin
					if (rise) begin
						nxt_s.acked = !sda_i; // R08
					end else if (fall) begin
						if (s_ff.acked) begin
							load_rd = 1'b1; // R15
						end else begin
							nxt_s.state = S_WSTOP; // R09
						end
					end
				end
				default: begin
					nxt_s.state = S_IDLE;
					nxt_s.oe_n = 1'b1;
				end
			endcase
		end
		// shared byte load: first bit is driven right after the fall
		if (load_rd) begin
			nxt_s.shreg = rbyte;
			nxt_s.oe_n = rbyte[7]; // R01 R08
			nxt_s.bitcnt = 4'h0;
			nxt_s.addr = s_ff.addr + 8'h1; // R19
			nxt_s.state = S_RDAT;
		end
		// register slave: answer one cycle after the request, once
		nxt_s.ack = req;
		if (req) begin
			nxt_s.dat = 32'h0;
			if (we_i && sel_i[0]) begin
				if (adr_i == CTRL_OFS) begin
					nxt_s.en = dat_i[CTRL_EN_BIT];
				end
				if (adr_i == PROT_OFS) begin
					nxt_s.prot = dat_i[7:0];
				end
			end else if (!we_i) begin
				if (adr_i == CTRL_OFS) begin
					nxt_s.dat[CTRL_EN_BIT] = s_ff.en;
				end else if (adr_i == STAT_OFS) begin
					nxt_s.dat[STAT_BUSY_BIT] = s_ff.busy;
					nxt_s.dat[STAT_SEL_BIT] = !(s_ff.state inside {S_IDLE, S_WSTOP});
					nxt_s.dat[STAT_STBY_BIT] = s_ff.state == S_IDLE && !s_ff.busy;
					nxt_s.dat[STAT_ADDR_LSB +: ADDR_W] = s_ff.addr;
				end else if (adr_i == PROT_OFS) begin
					nxt_s.dat[7:0] = s_ff.prot;
				end else if (mem_hit) begin
					nxt_s.dat[7:0] = mem[adr_i[9:2]];
				end
			end
		end
		// serial update of the protection byte wins over software
		if (do_commit && s_ff.ppend) begin
			nxt_s.prot = s_ff.pval;
		end
	end

	// state register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_ff <= '0;
			s_ff.state <= S_IDLE;
			s_ff.scl_q <= 1'b1;
			s_ff.sda_q <= 1'b1;
			s_ff.oe_n <= 1'b1;
			s_ff.en <= CTRL_EN_RST;
			s_ff.prot <= PROT_RST;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// array: software loads it, the page buffer lands on stop
	always_ff @(posedge clk_i) begin
		if (req && we_i && sel_i[0] && mem_hit) begin
			mem[adr_i[9:2]] <= dat_i[7:0];
		end
		if (do_commit) begin
			for (int i = 0; i < PAGE_BYTES; i++) begin
				if (s_ff.pmask[i]) begin
					mem[{s_ff.pbase, 4'(i)}] <= s_ff.pbuf[i]; // R17
				end
			end
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	idle_line_free_a: assert property ( // R03
		s_ff.state inside {S_IDLE, S_WSTOP} |-> s_ff.oe_n)
		else $error("slave drives line while not addressed");
	select_ack_a: assert property ( // R06
		s_ff.state == S_DSEL && fall && s_ff.bitcnt == 4'h8 && match && !stop && !start
		|=> !sda_oe_n_o && s_ff.state == S_ACKS)
		else $error("matching select byte not acked");
	stop_standby_a: assert property ( // R04
		stop |=> s_ff.state == S_IDLE && sda_oe_n_o)
		else $error("stop did not return to standby");
	busy_deaf_a: assert property ( // R18
		s_ff.busy |-> sda_oe_n_o && s_ff.state inside {S_IDLE, S_WSTOP})
		else $error("bus answered during program cycle");
	write_ack_a: assert property ( // R07
		s_ff.state == S_WDAT && fall && s_ff.bitcnt == 4'h8 && !stop && !start
		|=> s_ff.state == S_ACKW && !sda_oe_n_o)
		else $error("write byte not acked");
	nack_end_a: assert property ( // R09
		s_ff.state == S_RACK && fall && !s_ff.acked && !stop && !start
		|=> s_ff.state == S_WSTOP ##1 sda_oe_n_o)
		else $error("slave kept sending after no ack");
	addr_step_a: assert property ( // R19
		s_ff.state == S_ACKW && $past(s_ff.state) == S_WDAT
		|-> s_ff.addr == $past(s_ff.addr) + 8'h1)
		else $error("address counter did not step");
	commit_busy_a: assert property ( // R18
		stop && s_ff.pmask != 16'h0 |=> s_ff.busy && s_ff.pcnt == 32'h0)
		else $error("program cycle not started");
	line_still_a: assert property ( // R01
		scl_i && s_ff.scl_q && s_ff.state != S_IDLE |=> $stable(sda_oe_n_o) || stop || start)
		else $error("line changed while clock high");
	release_ack_a: assert property ( // R05
		s_ff.state inside {S_ACKA, S_ACKW} && fall && !stop && !start |=> sda_oe_n_o)
		else $error("ack not released after ninth clock");

	read_seen_c: cover property (s_ff.state == S_RACK && fall && s_ff.acked);
	commit_seen_c: cover property (do_commit);
	nack_seen_c: cover property (s_ff.state == S_RACK ##1 s_ff.state == S_WSTOP);
	prot_seen_c: cover property (s_ff.prot_sel && s_ff.state == S_ACKS);
endmodule : eeprom_serial_slave

// ==== pkg/eeprom_serial_pkg.sv ====
package eeprom_serial_pkg;
	// timing and sizes: program cycle is a longest time, so the count rounds down
	localparam int CLK_MHZ = 200;
	localparam int PROG_TIME_MS = 10;
	localparam int PROG_CYCLES_DEF = PROG_TIME_MS * 1000 * CLK_MHZ;
	localparam int PAGE_BYTES = 16;
	localparam int ADDR_W = 8;
	// register byte offsets
	localparam logic [11:0] CTRL_OFS = 12'h000;
	localparam logic [11:0] STAT_OFS = 12'h004;
	localparam logic [11:0] PROT_OFS = 12'h008;
	localparam logic [1:0] MEM_WIN = 2'h1; // adr[11:10], window at 0x400
	// field positions
	localparam int CTRL_EN_BIT = 0;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_SEL_BIT = 1;
	localparam int STAT_STBY_BIT = 2;
	localparam int STAT_ADDR_LSB = 8;
	// reset values, then the bit count per byte
	localparam logic CTRL_EN_RST = 1'h1;
	localparam logic [7:0] PROT_RST = 8'h00;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	typedef enum logic [9:0] {
		S_IDLE = 10'h001,
		S_DSEL = 10'h002,
		S_ACKS = 10'h004,
		S_ADDR = 10'h008,
		S_ACKA = 10'h010,
		S_WDAT = 10'h020,
		S_ACKW = 10'h040,
		S_RDAT = 10'h080,
		S_RACK = 10'h100,
		S_WSTOP = 10'h200
	} ser_state_t;

	typedef struct packed {
		ser_state_t state;
		logic scl_q;
		logic sda_q;
		logic [7:0] shreg;
		logic [3:0] bitcnt;
		logic [7:0] addr;
		logic prot_sel;
		logic rd;
		logic oe_n;
		logic acked;
		logic [3:0] pbase;
		logic [15:0] pmask;
		logic [15:0][7:0] pbuf;
		logic ppend;
		logic [7:0] pval;
		logic busy;
		logic [31:0] pcnt;
		logic en;
		logic [7:0] prot;
		logic ack;
		logic [31:0] dat;
	} core_t;
endpackage : eeprom_serial_pkg

// ==== test/serial_host_model.sv ====
`timescale 1ns/1ps
module serial_host_model (
	input wire logic clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_o
);
	// idle bus: clock stands high, data released to the pull-up
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	// four system clocks per phase, above the two the slave needs to sample
	task automatic hold();
		repeat (4) @(posedge clk_i);
	endtask : hold
	// also serves as repeated start, entered with the clock low
	task automatic start();
		sda_o <= 1'b1;
		hold();
		scl_o <= 1'b1;
		hold();
		sda_o <= 1'b0;
		hold();
		scl_o <= 1'b0;
		hold();
	endtask : start
	task automatic stop();
		sda_o <= 1'b0;
		hold();
		scl_o <= 1'b1;
		hold();
		sda_o <= 1'b1;
		hold();
	endtask : stop
	// eight bits msb first, then the acknowledge slot; a 1 releases the line
	task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
		for (int i = 8; i >= 0; i--) begin
			sda_o <= tx[i];
			hold();
			scl_o <= 1'b1;
			hold();
			rx[i] = sda_i;
			scl_o <= 1'b0;
			hold();
		end
		// the line keeps the ack slot's level; the next task sets it once
	endtask : xfer
endmodule : serial_host_model

// ==== test/module_config_eeprom_serial_slave_test.sv ====
`timescale 1ns/1ps
module module_config_eeprom_serial_slave_test;
	import eeprom_serial_pkg::*;
	localparam logic [3:0] MT = 4'hC; // arbitrary value
	localparam logic [3:0] PT = 4'h3; // arbitrary value
	localparam logic [2:0] PINS = 3'h5;
	logic clk, rst, scl, hsda, so, oe_n, wp, we, cyc, stb, ack;
	logic [11:0] adr;
	logic [31:0] wdat, rdat, q;
	logic [8:0] r;
	wire logic sda = hsda & (oe_n | so); // open drain with pull-up
	int n_errors = 0;
	int checks = 0;
	serial_host_model host (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_o(hsda));
	eeprom_serial_slave #(.PROG_CYCLES(200), .MEM_TYPE(MT), .PROT_TYPE(PT)) DUT (
		.clk_i(clk), .rst_i(rst), .scl_i(scl), .sda_i(sda), .sda_o(so),
		.sda_oe_n_o(oe_n), .select_pin_bit2_i(PINS[2]), .select_pin_bit1_i(PINS[1]),
		.select_pin_bit0_i(PINS[0]), .write_protect_input_i(wp), .adr_i(adr),
		.dat_i(wdat), .dat_o(rdat), .we_i(we), .sel_i(4'hF), .stb_i(stb), .cyc_i(cyc),
		.ack_o(ack));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : close_out
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			n_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	// classic cycle: hold until ack is sampled high, take data at that edge, then idle
	task automatic wb(input logic [11:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		adr <= a;
		we <= w;
		wdat <= d;
		// read right after the edge, ack and data are the values that edge sampled
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50) n_errors++;
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk);
	endtask : wb
	function automatic logic [11:0] madr(input logic [7:0] a);
		return {MEM_WIN, a, 2'b00};
	endfunction : madr
	// serial write of n bytes from base, every byte expected acked
	task automatic swr(input logic [3:0] t, input logic [7:0] a, input int n,
		input logic [7:0] base);
		host.start();
		host.xfer({t, PINS, 1'b0, 1'b1}, r);
		chk(r[0], 0);
		host.xfer({a, 1'b1}, r);
		chk(r[0], 0);
		for (int i = 0; i < n; i++) begin
			host.xfer({base + 8'(i), 1'b1}, r);
			chk(r[0], 0);
		end
		host.stop();
	endtask : swr
	initial begin
		rst = 1'b1;
		wp = 1'b0;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 12'h000;
		wdat = 32'h0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		wb(12'h00C, 1'b0, 32'h0);
		chk(q, 32'h0);
		wb(CTRL_OFS, 1'b0, 32'h0);
		chk(q, 32'h1);
		wb(PROT_OFS, 1'b0, 32'h0);
		chk(q, 32'h0);
		$display("test reset values done");
		// serial side switched off: a start must go unanswered
		wb(CTRL_OFS, 1'b1, 32'h0);
		host.start();
		host.xfer({MT, PINS, 1'b0, 1'b1}, r);
		chk(r[0], 1);
		host.stop();
		wb(CTRL_OFS, 1'b1, 32'h1);
		wb(STAT_OFS, 1'b0, 32'h0);
		chk(q, 32'h4);
		$display("test enable done");
		swr(MT, 8'h10, 1, 8'hA5);
		wb(STAT_OFS, 1'b0, 32'h0);
		chk(q[STAT_BUSY_BIT], 1);
		host.start();
		host.xfer({MT, PINS, 1'b0, 1'b1}, r);
		chk(r[0], 1);
		host.stop();
		repeat (250) @(posedge clk);
		wb(madr(8'h10), 1'b0, 32'h0);
		chk(q, 32'hA5);
		$display("test byte write done");
		wp <= 1'b1;
		swr(MT, 8'h10, 1, 8'h3C);
		wp <= 1'b0;
		repeat (250) @(posedge clk);
		wb(madr(8'h10), 1'b0, 32'h0);
		chk(q, 32'hA5);
		$display("test write protect done");
		swr(MT, 8'h20, 16, 8'h40);
		repeat (250) @(posedge clk);
		for (int i = 0; i < 16; i++) begin
			wb(madr(8'h20 + 8'(i)), 1'b0, 32'h0);
			chk(q, 32'h40 + i);
		end
		$display("test page write done");
		host.start();
		host.xfer({MT, PINS, 1'b0, 1'b1}, r);
		host.xfer({8'h20, 1'b1}, r);
		host.start();
		host.xfer({MT, PINS, 1'b1, 1'b1}, r);
		chk(r[0], 0);
		host.xfer(9'h1FE, r);
		chk(r[8:1], 32'h40);
		host.xfer(9'h1FF, r);
		chk(r[8:1], 32'h41);
		host.xfer(9'h1FF, r);
		chk(r, 32'h1FF);
		host.stop();
		host.start();
		host.xfer({MT, PINS, 1'b1, 1'b1}, r);
		host.xfer(9'h1FF, r);
		chk(r[8:1], 32'h42);
		host.stop();
		$display("test reads done");
		host.start();
		host.xfer({MT, 3'h4, 1'b0, 1'b1}, r);
		chk(r[0], 1);
		host.stop();
		wb(PROT_OFS, 1'b1, 32'h5A);
		host.start();
		host.xfer({PT, PINS, 1'b1, 1'b1}, r);
		host.xfer(9'h1FF, r);
		chk(r[8:1], 32'h5A);
		host.stop();
		$display("test select codes done");
		// idle, standby, counter past the protection read
		wb(STAT_OFS, 1'b0, 32'h0);
		chk(q, 32'h2404);
		// serial write to the protection byte lands at the stop
		swr(PT, 8'h00, 1, 8'h66);
		wb(STAT_OFS, 1'b0, 32'h0);
		chk(q, 32'h101);
		repeat (250) @(posedge clk);
		wb(PROT_OFS, 1'b0, 32'h0);
		chk(q, 32'h66);
		$display("test protection write done");
		close_out();
	end
	// a full run needs well under twenty thousand clocks
	initial begin
		repeat (40000) @(posedge clk);
		n_errors++;
		close_out();
	end
endmodule : module_config_eeprom_serial_slave_test
